//--- logic/uqc_if.sv
// uqc_if: link between the queue controller and the uart channel with its ram
// assumes: one clock for both ends, supplied by the testbench
`timescale 1ns/1ns
interface uqc_if;
	logic ram_req;
	logic ram_we;
	logic [7:0] ram_addr;
	logic [7:0] ram_wdata;
	logic [7:0] ram_rdata;
	logic ram_ack;
	logic tx_queue_on;
	logic rx_queue_on;
	logic tx_load;
	logic [7:0] tx_byte;
	logic tx_done;
	logic rx_valid;
	logic [7:0] rx_byte;
	logic rx_busy;

	modport queue (
		output ram_req, ram_we, ram_addr, ram_wdata, tx_queue_on, rx_queue_on, tx_load, tx_byte,
		input ram_rdata, ram_ack, tx_done, rx_valid, rx_byte, rx_busy
	);
	modport uart (
		input ram_req, ram_we, ram_addr, ram_wdata, tx_queue_on, rx_queue_on, tx_load, tx_byte,
		output ram_rdata, ram_ack, tx_done, rx_valid, rx_byte, rx_busy
	);
endinterface

//--- logic/uqc_pkg.sv
// uqc_pkg: register indices, field positions, reset values and states of the uart queue
// assumes: shared by the queue controller end and the uart/ram end
package uqc_pkg;

	// ****************************************
	// register indices (byte address is four times the index)
	// ****************************************
	localparam logic [31:0] IDX_RXC = 32'hffff8b00;
	localparam logic [31:0] IDX_TXC = 32'hffff8b01;
	localparam logic [31:0] IDX_TXP = 32'hffff8b03;
	localparam logic [31:0] IDX_TXN = 32'hffff8b05;
	localparam logic [31:0] IDX_RXP = 32'hffff8b07;
	localparam logic [31:0] IDX_RXN = 32'hffff8b09;
	localparam logic [31:0] IDX_RXM = 32'hffff8b0b;
	localparam int APB_AW = 12;

	// ****************************************
	// field positions
	// ****************************************
	localparam int TXC_TDONE = 7;
	localparam int TXC_RDONE = 6;
	localparam int TXC_TWAIT = 4;
	localparam int TXC_TON = 3;
	localparam int TXC_TBYTE = 2;
	localparam int TXC_THOLD = 1;
	localparam int TXC_TGO = 0;
	localparam int RXC_RON = 7;
	localparam int RXC_RCMP = 6;
	localparam int RXC_RBYTE = 5;
	localparam int RXC_RKEEP = 4;
	localparam int RXC_ROVR = 3;
	localparam int RXC_RWRAP = 2;
	localparam int RXC_RHOLD = 1;
	localparam int RXC_RGO = 0;

	// ****************************************
	// reset and wrap values
	// ****************************************
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [7:0] PTR_WRAP = 8'h00;

	typedef enum logic [1:0] {
		TX_IDLE = 2'h0,
		TX_CHECK = 2'h1,
		TX_FETCH = 2'h2,
		TX_WAIT = 2'h3
	} uqc_tx_st_t;

	typedef enum logic [0:0] {
		RX_IDLE = 1'h0,
		RX_WRITE = 1'h1
	} uqc_rx_st_t;

	function automatic logic [APB_AW-1:0] reg_addr(input logic [31:0] idx);
		return {idx[APB_AW-3:0], 2'b00};
	endfunction

	function automatic logic [7:0] dec_sat(input logic [7:0] v);
		return (v == 8'h00) ? 8'h00 : v - 8'h01;
	endfunction

endpackage

//--- logic/uqc_queue.sv
// uqc_queue: uart queue controller, apb register slave plus transmit and receive sequencers
// assumes: apb master on clk_sys; uart/ram end on the queue modport, same clock
//
// Notes on behaviour
// R1: wrap on: empty receive count zeroes pointer
// R2: halt keeps byte in flight, drops later
// R3: receive go cleared at end, kept in halt
// R4: software stops uart receive at uart itself
// R5: transmit control bit layout, clear/set-only bits
// R6: transmit flag at zero count, per-byte optional
// R7: receive flag at end, match, per byte
// R8: flags interrupt on rising edge only
// R9: waiting bit high while awaiting transmit done
// R10: queue off means direct uart buffer access
// R11: halt lets loaded byte finish, holds next
// R12: transmit go cleared when frame ends
// R13: transmit control bits zero after reset
// R14: fetch byte, load uart, step count, pointer
// R15: after transmit done, repeat while count nonzero
// R16: halt tested before each count test
// R17: software sets up everything before control
// R18: pointer values select 256-byte ram window
// R19: receive stores byte, steps pointer and count
// R20: cpu ram access stalls behind queue access
// R21: pointers wrap at 256, counts stop at zero
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ns
module uqc_queue
	import uqc_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [uqc_pkg::APB_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	uqc_if.queue q,
	output logic tx_irq_pulse,
	output logic rx_irq_pulse
);
	import uqc_pkg::*;

	typedef struct packed {
		logic tx_done_flag;
		logic rx_done_flag;
		logic tx_waiting_flag;
		logic tx_queue_on;
		logic tx_per_byte_irq_on;
		logic tx_hold;
		logic tx_go_flag;
		logic rx_queue_on;
		logic rx_compare_on;
		logic rx_per_byte_irq_on;
		logic rx_keep_going;
		logic rx_overrun_flag;
		logic rx_wrap_on_empty;
		logic rx_hold;
		logic rx_go_flag;
		logic [7:0] tx_ptr;
		logic [7:0] tx_cnt;
		logic [7:0] rx_ptr;
		logic [7:0] rx_cnt;
		logic [7:0] rx_match;
		uqc_tx_st_t tx_st;
		uqc_rx_st_t rx_st;
		logic [7:0] rx_data;
		logic rx_hold_prev;
		logic rx_grace;
		logic ram_req;
		logic ram_we;
		logic [7:0] ram_addr;
		logic [7:0] ram_wdata;
		logic tx_load;
		logic [7:0] tx_byte;
		logic tx_irq;
		logic rx_irq;
		logic [31:0] prdata;
	} uqc_q_state_t;

	uqc_q_state_t s_q;
	uqc_q_state_t s_d;

	// ****************************************
	// register decode
	// ****************************************
	function automatic logic reg_hit(input logic [APB_AW-1:0] a);
		return (a == reg_addr(IDX_RXC)) || (a == reg_addr(IDX_TXC)) || (a == reg_addr(IDX_TXP))
			|| (a == reg_addr(IDX_TXN)) || (a == reg_addr(IDX_RXP)) || (a == reg_addr(IDX_RXN))
			|| (a == reg_addr(IDX_RXM));
	endfunction

	function automatic logic [7:0] reg_read(input uqc_q_state_t s, input logic [APB_AW-1:0] a);
		logic [7:0] r;
		r = 8'h00;
		if (a == reg_addr(IDX_TXC)) begin
			r = {s.tx_done_flag, s.rx_done_flag, 1'b0, s.tx_waiting_flag,
				s.tx_queue_on, s.tx_per_byte_irq_on, s.tx_hold, s.tx_go_flag}; // R5
		end else if (a == reg_addr(IDX_RXC)) begin
			r = {s.rx_queue_on, s.rx_compare_on, s.rx_per_byte_irq_on, s.rx_keep_going,
				s.rx_overrun_flag, s.rx_wrap_on_empty, s.rx_hold, s.rx_go_flag};
		end else if (a == reg_addr(IDX_TXP)) begin
			r = s.tx_ptr;
		end else if (a == reg_addr(IDX_TXN)) begin
			r = s.tx_cnt;
		end else if (a == reg_addr(IDX_RXP)) begin
			r = s.rx_ptr;
		end else if (a == reg_addr(IDX_RXN)) begin
			r = s.rx_cnt;
		end else if (a == reg_addr(IDX_RXM)) begin
			r = s.rx_match;
		end
		return r;
	endfunction

	logic apb_wr;

	assign apb_wr = psel & penable & pwrite;
	// no wait state: read data is caught in the setup cycle so it comes from a flop
	assign pready = psel & penable;
	assign pslverr = psel & penable & ~reg_hit(paddr);
	assign prdata = s_q.prdata;
	assign tx_irq_pulse = s_q.tx_irq;
	assign rx_irq_pulse = s_q.rx_irq;
	assign q.ram_req = s_q.ram_req;
	assign q.ram_we = s_q.ram_we;
	assign q.ram_addr = s_q.ram_addr;
	assign q.ram_wdata = s_q.ram_wdata;
	assign q.tx_queue_on = s_q.tx_queue_on; // R10
	assign q.rx_queue_on = s_q.rx_queue_on;
	assign q.tx_load = s_q.tx_load;
	assign q.tx_byte = s_q.tx_byte;

	always_comb begin
		s_d = s_q;
		s_d.tx_load = 1'b0;
		if (psel && !penable) begin
			s_d.prdata = {24'h000000, reg_read(s_q, paddr)};
		end

		// ****************************************
		// software writes; hardware below overrides them in the same cycle
		// ****************************************
		if (apb_wr) begin
			if (paddr == reg_addr(IDX_TXC)) begin
				s_d.tx_done_flag = s_q.tx_done_flag & pwdata[TXC_TDONE]; // R5
				s_d.rx_done_flag = s_q.rx_done_flag & pwdata[TXC_RDONE]; // R5
				s_d.tx_queue_on = pwdata[TXC_TON];
				s_d.tx_per_byte_irq_on = pwdata[TXC_TBYTE];
				s_d.tx_hold = pwdata[TXC_THOLD];
				s_d.tx_go_flag = s_q.tx_go_flag | pwdata[TXC_TGO]; // R5 R12
			end else if (paddr == reg_addr(IDX_RXC)) begin
				s_d.rx_queue_on = pwdata[RXC_RON];
				s_d.rx_compare_on = pwdata[RXC_RCMP];
				s_d.rx_per_byte_irq_on = pwdata[RXC_RBYTE];
				s_d.rx_keep_going = pwdata[RXC_RKEEP];
				s_d.rx_overrun_flag = s_q.rx_overrun_flag & pwdata[RXC_ROVR];
				s_d.rx_wrap_on_empty = pwdata[RXC_RWRAP];
				s_d.rx_hold = pwdata[RXC_RHOLD];
				s_d.rx_go_flag = s_q.rx_go_flag | pwdata[RXC_RGO]; // R3
			end else if (paddr == reg_addr(IDX_TXP)) begin
				s_d.tx_ptr = pwdata[7:0];
			end else if (paddr == reg_addr(IDX_TXN)) begin
				s_d.tx_cnt = pwdata[7:0];
			end else if (paddr == reg_addr(IDX_RXP)) begin
				s_d.rx_ptr = pwdata[7:0];
			end else if (paddr == reg_addr(IDX_RXN)) begin
				s_d.rx_cnt = pwdata[7:0];
			end else if (paddr == reg_addr(IDX_RXM)) begin
				s_d.rx_match = pwdata[7:0];
			end
		end

		// ****************************************
		// ram port: one access at a time, receive first
		// ****************************************
		if (s_q.ram_req && q.ram_ack) begin
			s_d.ram_req = 1'b0;
			if (s_q.ram_we) begin
				s_d.rx_st = RX_IDLE;
				s_d.rx_ptr = s_q.rx_ptr + 8'h01; // R19 R21
				s_d.rx_cnt = dec_sat(s_q.rx_cnt); // R19 R21
				if (s_q.rx_per_byte_irq_on) begin
					s_d.rx_done_flag = 1'b1; // R7
				end
				if (s_q.rx_compare_on && s_q.rx_data == s_q.rx_match) begin
					s_d.rx_done_flag = 1'b1; // R7
					s_d.rx_go_flag = 1'b0;
				end
				if (dec_sat(s_q.rx_cnt) == 8'h00) begin
					s_d.rx_done_flag = 1'b1; // R7
					if (s_q.rx_wrap_on_empty) begin
						s_d.rx_ptr = PTR_WRAP; // R1
					end
					if (!s_q.rx_keep_going) begin
						s_d.rx_go_flag = 1'b0; // R3
					end
				end
			end else begin
				s_d.tx_byte = q.ram_rdata; // R14
				s_d.tx_load = 1'b1; // R14
				s_d.tx_ptr = s_q.tx_ptr + 8'h01; // R14 R21
				s_d.tx_cnt = dec_sat(s_q.tx_cnt); // R14 R21
				s_d.tx_waiting_flag = 1'b1; // R9
				s_d.tx_st = TX_WAIT;
			end
		end else if (!s_q.ram_req) begin
			if (s_q.rx_st == RX_WRITE) begin
				s_d.ram_req = 1'b1;
				s_d.ram_we = 1'b1;
				s_d.ram_addr = s_q.rx_ptr; // R18
				s_d.ram_wdata = s_q.rx_data;
			end else if (s_q.tx_st == TX_FETCH) begin
				s_d.ram_req = 1'b1;
				s_d.ram_we = 1'b0;
				s_d.ram_addr = s_q.tx_ptr; // R18
			end
		end

		// ****************************************
		// transmit sequencer
		// ****************************************
		unique case (s_q.tx_st)
			TX_IDLE: begin
				if (s_q.tx_queue_on && s_q.tx_go_flag) begin
					s_d.tx_st = TX_CHECK; // R10
				end
			end
			TX_CHECK: begin
				if (!s_q.tx_queue_on) begin
					s_d.tx_go_flag = 1'b0;
					s_d.tx_st = TX_IDLE;
				end else if (s_q.tx_hold) begin
					s_d.tx_st = TX_CHECK; // R11 R16
				end else if (s_q.tx_cnt != 8'h00) begin
					s_d.tx_st = TX_FETCH; // R15
				end else begin
					s_d.tx_done_flag = 1'b1; // R6
					s_d.tx_go_flag = 1'b0; // R12
					s_d.tx_st = TX_IDLE;
				end
			end
			TX_FETCH: begin
			end
			TX_WAIT: begin
				if (q.tx_done) begin
					s_d.tx_waiting_flag = 1'b0; // R9
					s_d.tx_st = TX_CHECK; // R15
					if (s_q.tx_per_byte_irq_on) begin
						s_d.tx_done_flag = 1'b1; // R6
					end
				end
			end
		endcase

		// ****************************************
		// receive acceptance
		// ****************************************
		// grace covers the one byte already on the line when halt is raised
		s_d.rx_hold_prev = s_q.rx_hold;
		if (!s_q.rx_hold) begin
			s_d.rx_grace = 1'b0;
		end else if (!s_q.rx_hold_prev && q.rx_busy) begin
			s_d.rx_grace = 1'b1; // R2
		end
		if (q.rx_valid && s_q.rx_queue_on) begin
			if (!s_q.rx_go_flag) begin
				s_d.rx_overrun_flag = 1'b1;
			end else if (s_q.rx_hold && !s_q.rx_grace) begin
				// dropped: leave rx_st alone so a write acked this cycle is not replayed
				s_d.rx_data = s_q.rx_data; // R2
			end else if (s_q.rx_st == RX_IDLE) begin
				s_d.rx_st = RX_WRITE; // R19
				s_d.rx_data = q.rx_byte;
				s_d.rx_grace = 1'b0; // R2
			end
		end
		if (!s_d.rx_queue_on) begin
			s_d.rx_go_flag = 1'b0; // R3
		end

		s_d.tx_irq = s_d.tx_done_flag & ~s_q.tx_done_flag; // R8
		s_d.rx_irq = s_d.rx_done_flag & ~s_q.rx_done_flag; // R8
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			s_q <= '0; // R13
			s_q.tx_st <= TX_IDLE;
			s_q.rx_st <= RX_IDLE;
		end else begin
			s_q <= s_d;
		end
	end

endmodule // uqc_queue

//--- logic/uqc_uart_ram.sv
// uqc_uart_ram: uart channel data path and 256-byte internal ram seen by cpu and queue
// assumes: serializer and cpu on user ports run on clk_sys; queue end on the uart modport
`timescale 1ns/1ns
module uqc_uart_ram
	import uqc_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rstn,
	uqc_if.uart u,
	input wire logic cpu_req,
	input wire logic cpu_we,
	input wire logic [7:0] cpu_addr,
	input wire logic [7:0] cpu_wdata,
	output logic [7:0] cpu_rdata,
	output logic cpu_ready,
	input wire logic cpu_tx_wr,
	input wire logic [7:0] cpu_tx_data,
	output logic [7:0] cpu_rx_data,
	output logic cpu_rx_new,
	input wire logic uart_rx_on,
	output logic line_tx_valid,
	output logic [7:0] line_tx_data,
	input wire logic line_tx_done,
	input wire logic line_rx_valid,
	input wire logic [7:0] line_rx_data,
	input wire logic line_rx_busy
);
	import uqc_pkg::*;

	typedef struct packed {
		logic ack;
		logic [7:0] qrdata;
		logic cpu_ready;
		logic [7:0] cpu_rdata;
		logic tx_valid;
		logic [7:0] uart_data_buffer;
		logic tx_done;
		logic rx_valid;
		logic [7:0] rx_byte;
		logic rx_busy;
		logic [7:0] cpu_rx_data;
		logic cpu_rx_new;
	} uqc_u_state_t;

	uqc_u_state_t s_q;
	uqc_u_state_t s_d;
	logic [7:0] mem [256];
	logic q_go;
	logic cpu_go;

	// queue owns the ram while it requests; cpu waits, each access two clocks
	assign q_go = u.ram_req & ~s_q.ack; // R20
	assign cpu_go = cpu_req & ~u.ram_req & ~s_q.ack & ~s_q.cpu_ready; // R20

	assign u.ram_ack = s_q.ack;
	assign u.ram_rdata = s_q.qrdata;
	assign u.tx_done = s_q.tx_done;
	assign u.rx_valid = s_q.rx_valid;
	assign u.rx_byte = s_q.rx_byte;
	assign u.rx_busy = s_q.rx_busy;
	assign cpu_rdata = s_q.cpu_rdata;
	assign cpu_ready = s_q.cpu_ready;
	assign cpu_rx_data = s_q.cpu_rx_data;
	assign cpu_rx_new = s_q.cpu_rx_new;
	assign line_tx_valid = s_q.tx_valid;
	assign line_tx_data = s_q.uart_data_buffer;

	always_comb begin
		s_d = s_q;
		s_d.ack = q_go;
		s_d.cpu_ready = cpu_go;
		s_d.tx_valid = 1'b0;
		s_d.rx_valid = 1'b0;
		s_d.cpu_rx_new = 1'b0;
		if (q_go && !u.ram_we) begin
			s_d.qrdata = mem[u.ram_addr]; // R18
		end
		if (cpu_go && !cpu_we) begin
			s_d.cpu_rdata = mem[cpu_addr];
		end

		// ****************************************
		// uart data buffer: queue or cpu, never both
		// ****************************************
		if (u.tx_queue_on) begin
			if (u.tx_load) begin
				s_d.tx_valid = 1'b1; // R10
				s_d.uart_data_buffer = u.tx_byte;
			end
		end else if (cpu_tx_wr) begin
			s_d.tx_valid = 1'b1; // R10
			s_d.uart_data_buffer = cpu_tx_data;
		end
		s_d.tx_done = line_tx_done;
		s_d.rx_busy = line_rx_busy & uart_rx_on; // R4
		if (line_rx_valid && uart_rx_on) begin
			if (u.rx_queue_on) begin
				s_d.rx_valid = 1'b1;
				s_d.rx_byte = line_rx_data;
			end else begin
				s_d.cpu_rx_new = 1'b1;
				s_d.cpu_rx_data = line_rx_data;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (q_go && u.ram_we) begin
			mem[u.ram_addr] <= u.ram_wdata; // R18
		end else if (cpu_go && cpu_we) begin
			mem[cpu_addr] <= cpu_wdata;
		end
	end

endmodule // uqc_uart_ram

//--- tb/tb.sv
// tb: uart queue bench, controller and uart/ram end joined through uqc_if
// assumes: bench models the line serializer, the line receiver and the apb master
`timescale 1ns/1ns
module tb;
	import uqc_pkg::*;
	// byte address on the bus is four times the register index, low 12 bits kept
	localparam logic [11:0] A_RXC = {IDX_RXC[9:0], 2'b00};
	localparam logic [11:0] A_TXC = {IDX_TXC[9:0], 2'b00};
	localparam logic [11:0] A_TP = {IDX_TXP[9:0], 2'b00};
	localparam logic [11:0] A_TN = {IDX_TXN[9:0], 2'b00};
	localparam logic [11:0] A_RP = {IDX_RXP[9:0], 2'b00};
	localparam logic [11:0] A_RN = {IDX_RXN[9:0], 2'b00};
	localparam logic [11:0] A_RM = {IDX_RXM[9:0], 2'b00};
	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [APB_AW-1:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata;
	logic pready, pslverr, tx_irq_pulse, rx_irq_pulse, cpu_ready, cpu_rx_new;
	logic cpu_req = 1'b0;
	logic cpu_we = 1'b0;
	logic [7:0] cpu_addr = 8'h00;
	logic [7:0] cpu_wdata = 8'h00;
	logic cpu_tx_wr = 1'b0;
	logic [7:0] cpu_tx_data = 8'h00;
	logic [7:0] cpu_rdata, cpu_rx_data, line_tx_data;
	logic uart_rx_on = 1'b1;
	logic line_tx_valid;
	logic line_tx_done = 1'b0;
	logic line_rx_valid = 1'b0;
	logic [7:0] line_rx_data = 8'h00;
	logic line_rx_busy = 1'b0;
	logic [7:0] drx_q = 8'h00;
	int err_count = 0;
	int checks = 0;
	int n_tirq = 0;
	int n_rirq = 0;
	int ser_cnt = 0;
	logic [7:0] txq[$];
	always #20 clk_sys = ~clk_sys;
	uqc_if u_uqc_if();
	uqc_queue u_uqc_queue (.clk_sys, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .q(u_uqc_if.queue), .tx_irq_pulse, .rx_irq_pulse);
	uqc_uart_ram u_uqc_uart_ram (.clk_sys, .rstn, .u(u_uqc_if.uart), .cpu_req, .cpu_we,
		.cpu_addr, .cpu_wdata, .cpu_rdata, .cpu_ready, .cpu_tx_wr, .cpu_tx_data, .cpu_rx_data,
		.cpu_rx_new, .uart_rx_on, .line_tx_valid, .line_tx_data, .line_tx_done, .line_rx_valid,
		.line_rx_data, .line_rx_busy);
	uqc_asserts u_uqc_asserts (.clk_sys, .rstn, .ram_req(u_uqc_if.ram_req),
		.ram_we(u_uqc_if.ram_we), .ram_addr(u_uqc_if.ram_addr), .ram_wdata(u_uqc_if.ram_wdata),
		.ram_rdata(u_uqc_if.ram_rdata), .ram_ack(u_uqc_if.ram_ack),
		.tx_queue_on(u_uqc_if.tx_queue_on), .tx_load(u_uqc_if.tx_load),
		.tx_byte(u_uqc_if.tx_byte), .tx_done(u_uqc_if.tx_done),
		.rx_valid(u_uqc_if.rx_valid), .rx_byte(u_uqc_if.rx_byte));
	// serializer: each byte takes 8 clocks on the line before its done pulse
	always @(posedge clk_sys) begin
		line_tx_done <= (ser_cnt == 1) && !line_tx_valid;
		if (line_tx_valid === 1'b1) begin
			txq.push_back(line_tx_data);
			ser_cnt <= 8;
		end else if (ser_cnt != 0) begin
			ser_cnt <= ser_cnt - 1;
		end
		if (tx_irq_pulse === 1'b1) n_tirq++;
		if (rx_irq_pulse === 1'b1) n_rirq++;
		if (cpu_rx_new === 1'b1) drx_q <= cpu_rx_data;
	end
	// ****************************************
	// shared tasks
	// ****************************************
	task stop_test();
		$display("checks=%0d err_count=%0d", checks, err_count);
		if (err_count == 0 && checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task check(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task tmo(input logic bad);
		if (bad) begin
			err_count++;
			stop_test();
		end
	endtask
	// an idle cycle after each transfer keeps psel from being driven twice in one step
	task apb(input logic w, input logic [11:0] a, input logic [7:0] d, output logic [32:0] r);
		int i;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge clk_sys);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge clk_sys);
			i++;
		end while (pready !== 1'b1 && i < 50);
		r = {pslverr, prdata};
		psel <= 1'b0;
		penable <= 1'b0;
		tmo(i >= 50);
		@(posedge clk_sys);
	endtask
	task wr(input logic [11:0] a, input logic [7:0] d);
		logic [32:0] r;
		apb(1'b1, a, d, r);
	endtask
	task rd(input logic [11:0] a, input logic [7:0] e);
		logic [32:0] r;
		apb(1'b0, a, 8'h00, r);
		check(r[31:0], {24'h0, e});
	endtask
	task ram(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] r);
		int i;
		cpu_req <= 1'b1;
		cpu_we <= w;
		cpu_addr <= a;
		cpu_wdata <= d;
		i = 0;
		do begin
			@(posedge clk_sys);
			i++;
		end while (cpu_ready !== 1'b1 && i < 50);
		r = cpu_rdata;
		cpu_req <= 1'b0;
		tmo(i >= 50);
		@(posedge clk_sys);
	endtask
	task wq(input int n);
		int i;
		for (i = 0; i < 3000 && txq.size() < n; i++) @(posedge clk_sys);
		tmo(txq.size() < n);
	endtask
	task tx_go(input logic [7:0] p, input logic [7:0] n, input logic [7:0] c);
		txq.delete();
		wr(A_TP, p);
		wr(A_TN, n);
		wr(A_TXC, c);
	endtask
	task rx_byte(input logic [7:0] b);
		line_rx_valid <= 1'b1;
		line_rx_data <= b;
		line_rx_busy <= 1'b0;
		@(posedge clk_sys);
		line_rx_valid <= 1'b0;
		line_rx_data <= ~b;
		repeat (8) @(posedge clk_sys);
	endtask
	// ****************************************
	// scenarios
	// ****************************************
	task t_regs();
		logic [32:0] r;
		rd(A_TXC, 8'h00);
		rd(A_RXC, 8'h00);
		wr(A_TXC, 8'h30);
		rd(A_TXC, 8'h00);
		wr(A_RM, 8'ha5);
		rd(A_RM, 8'ha5);
		apb(1'b0, 12'h030, 8'h00, r);
		check({31'h0, r[32]}, 32'h1);
		$display("regs test done");
	endtask
	task t_tx();
		logic [7:0] r;
		ram(1'b1, 8'hfe, 8'h11, r);
		ram(1'b1, 8'hff, 8'h22, r);
		ram(1'b1, 8'h00, 8'h33, r);
		tx_go(8'hfe, 8'h03, 8'h09);
		wq(1);
		rd(A_TXC, 8'h19);
		wq(3);
		repeat (12) @(posedge clk_sys);
		foreach (txq[i]) check({24'h0, txq[i]}, 32'h11 * (i + 1));
		rd(A_TXC, 8'h88);
		rd(A_TP, 8'h01);
		rd(A_TN, 8'h00);
		check(n_tirq, 32'd1);
		$display("tx test done");
	endtask
	task t_tbyte();
		n_tirq = 0;
		tx_go(8'hfe, 8'h02, 8'h4d);
		wq(2);
		repeat (12) @(posedge clk_sys);
		check(n_tirq, 32'd1);
		rd(A_TXC, 8'h8c);
		tx_go(8'hfe, 8'h02, 8'h49);
		wq(1);
		wr(A_TXC, 8'h4b);
		repeat (40) @(posedge clk_sys);
		check(txq.size(), 32'd1);
		rd(A_TXC, 8'h0b);
		wr(A_TXC, 8'h49);
		wq(2);
		repeat (12) @(posedge clk_sys);
		check({24'h0, txq[1]}, 32'h22);
		rd(A_TXC, 8'h88);
		$display("tie and hold test done");
	endtask
	task t_direct();
		wr(A_TXC, 8'h40);
		txq.delete();
		cpu_tx_wr <= 1'b1;
		cpu_tx_data <= 8'h5a;
		@(posedge clk_sys);
		cpu_tx_wr <= 1'b0;
		wq(1);
		check({24'h0, txq[0]}, 32'h5a);
		$display("direct test done");
	endtask
	task t_rx();
		logic [7:0] r;
		wr(A_RP, 8'hfe);
		wr(A_RN, 8'h02);
		wr(A_RXC, 8'h85);
		rx_byte(8'h61);
		rx_byte(8'h62);
		rd(A_RP, 8'h00);
		rd(A_RN, 8'h00);
		rd(A_RXC, 8'h84);
		rd(A_TXC, 8'h40);
		ram(1'b0, 8'hff, 8'h00, r);
		check({24'h0, r}, 32'h62);
		check(n_rirq, 32'd1);
		wr(A_TXC, 8'h80);
		wr(A_RP, 8'h10);
		wr(A_RN, 8'h05);
		wr(A_RM, 8'h0d);
		wr(A_RXC, 8'hc1);
		rx_byte(8'h41);
		rx_byte(8'h0d);
		rx_byte(8'h77);
		rd(A_RP, 8'h12);
		rd(A_RN, 8'h03);
		rd(A_RXC, 8'hc8);
		check(n_rirq, 32'd2);
		$display("rx test done");
	endtask
	task t_rxhold();
		wr(A_RXC, 8'h80);
		wr(A_RP, 8'h20);
		wr(A_RN, 8'h04);
		wr(A_RXC, 8'h81);
		line_rx_busy <= 1'b1;
		wr(A_RXC, 8'h83);
		rx_byte(8'ha1);
		rx_byte(8'ha2);
		rd(A_RP, 8'h21);
		rd(A_RN, 8'h03);
		rd(A_RXC, 8'h83);
		wr(A_RXC, 8'h01);
		rd(A_RXC, 8'h00);
		wr(A_RXC, 8'h81);
		uart_rx_on <= 1'b0;
		rx_byte(8'ha3);
		rd(A_RN, 8'h03);
		rd(A_RP, 8'h21);
		uart_rx_on <= 1'b1;
		wr(A_RXC, 8'h00);
		rx_byte(8'h5c);
		check({24'h0, drx_q}, 32'h5c);
		rd(A_RN, 8'h03);
		$display("rx hold test done");
	endtask
	initial begin
		repeat (20) @(posedge clk_sys);
		rstn <= 1'b1;
		@(posedge clk_sys);
		t_regs();
		t_tx();
		t_tbyte();
		t_direct();
		t_rx();
		t_rxhold();
		stop_test();
	end
endmodule // tb

//--- tb/uqc_asserts.sv
// uqc_asserts: checks on the link between queue controller and uart/ram end
// assumes: instantiated in tb beside the interface; one clock, sync active-low reset
`timescale 1ns/1ns
module uqc_asserts (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic ram_req,
	input wire logic ram_we,
	input wire logic [7:0] ram_addr,
	input wire logic [7:0] ram_wdata,
	input wire logic [7:0] ram_rdata,
	input wire logic ram_ack,
	input wire logic tx_queue_on,
	input wire logic tx_load,
	input wire logic [7:0] tx_byte,
	input wire logic tx_done,
	input wire logic rx_valid,
	input wire logic [7:0] rx_byte
);
	// ****************************************
	// helpers
	// ****************************************
	// fly_q: a byte sits in the uart and its completion has not come back yet
	logic fly_q;
	logic [7:0] rx_last_q;
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			fly_q <= 1'b0;
			rx_last_q <= 8'h00;
		end else begin
			fly_q <= tx_load | (fly_q & ~tx_done);
			if (rx_valid) begin
				rx_last_q <= rx_byte;
			end
		end
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	property p_load_on; tx_load |-> tx_queue_on; endproperty
	a_load_on: assert property (p_load_on) else $error("uart loaded with queue off");
	property p_req_hold; ram_req && !ram_ack |=> ram_req && $stable(ram_addr) && $stable(ram_we);
	endproperty
	a_req_hold: assert property (p_req_hold) else $error("ram request dropped early");
	property p_ack_bound; $rose(ram_req) |-> ##[1:4] ram_ack; endproperty
	a_ack_bound: assert property (p_ack_bound) else $error("ram access too slow");
	property p_ack_req; ram_ack |-> ram_req; endproperty
	a_ack_req: assert property (p_ack_req) else $error("ram ack without request");
	property p_one_flight; tx_load |-> !fly_q; endproperty
	a_one_flight: assert property (p_one_flight) else $error("second byte before done");
	property p_tx_byte; tx_load |-> $past(ram_ack) && !$past(ram_we) && tx_byte == $past(ram_rdata);
	endproperty
	a_tx_byte: assert property (p_tx_byte) else $error("uart byte not the ram byte");
	property p_rx_store; ram_req && ram_we |-> ram_wdata == rx_last_q; endproperty
	a_rx_store: assert property (p_rx_store) else $error("stored byte not received one");
	property p_load_pulse; tx_load |=> !tx_load [*2]; endproperty
	a_load_pulse: assert property (p_load_pulse) else $error("uart load repeated");
endmodule // uqc_asserts
